// File: hw/sslss_top.sv
// supply supervisor low-power state selector with wishbone registers
// assumes a classic wishbone master on clk_i and a synchronous reset
//
// Contract
// RULE_01 - active/light: supervisor off, normal or full from enable and fp
// RULE_02 - enabled supervisor without keep-select turns off in deep modes
// RULE_03 - keep-select: manual holds state, automatic lowers one level
// RULE_04 - monitor off, normal or full; auto lowers one level in deep
// RULE_05 - software waits for both settle flags low before deep entry
// RULE_06 - software may choose slow low-side wake-up, about 150 us
// RULE_07 - software may keep high side on and manual instead
// RULE_08 - low side fast when a unit is disabled or at full performance
// RULE_09 - flag enabled normal supervisor dropping off or under auto
// RULE_10 - flag enabled normal monitor under automatic control
// RULE_11 - hazard output is 1 when affected, 0 otherwise
// RULE_12 - software may add 150 us delay for fast interrupt service
// RULE_13 - affected deep entry may hang wake-up until a reset
// RULE_14 - hazard recomputed from registered bits, valid cycle after write
`timescale 1ns/100ps
`default_nettype none
`include "sslss_defs.svh"
module sslss_top
    import sslss_pkg::*;
(
    input wire logic clk_i,              // system clock
    input wire logic rst_i,              // synchronous reset
    input wire logic wb_cyc_i,           // bus cycle
    input wire logic wb_stb_i,           // strobe
    input wire logic wb_we_i,            // write enable
    input wire logic [7:0] wb_adr_i,     // byte address
    input wire logic [3:0] wb_sel_i,     // byte lanes
    input wire logic [31:0] wb_dat_i,    // write data
    output logic [31:0] wb_dat_o,        // read data
    output logic wb_ack_o,               // acknowledge
    output sslss_pwr_e high_sup_state_o, // high-side supervisor state
    output sslss_pwr_e high_mon_state_o, // high-side monitor state
    output logic hazard_o,               // affected configuration
    output logic wake_blocked_o,         // wake-up hang latched
    output logic irq_o                   // interrupt, level
);
    localparam int SETTLE_MAX = 130;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction : hit

    // ---------------- bus handshake
    logic ack_q;
    logic ack_d;
    logic [31:0] dat_q;
    logic [31:0] dat_d;
    logic req;
    logic wr_fire;
    logic lane0;

    // registers
    logic [`SSLSS_HCTL_W-1:0] hctl_q;
    logic [`SSLSS_HCTL_W-1:0] hctl_d;
    logic [`SSLSS_LCTL_W-1:0] lctl_q;
    logic [`SSLSS_LCTL_W-1:0] lctl_d;
    logic [`SSLSS_PMODE_W-1:0] pmode_q;
    logic [`SSLSS_PMODE_W-1:0] pmode_d;
    logic [`SSLSS_IRQ_W-1:0] ists_q;
    logic [`SSLSS_IRQ_W-1:0] ists_d;
    logic [`SSLSS_IRQ_W-1:0] imsk_q;
    logic [`SSLSS_IRQ_W-1:0] imsk_d;
    logic [`SSLSS_IRQ_W-1:0] ev;
    logic irq_q;
    logic irq_d;

    // settle counters, index 0 low side, 1 high side
    logic [1:0] ctl_wr;
    logic [`SSLSS_CNT_W-1:0] settle_q [2];
    logic [`SSLSS_CNT_W-1:0] settle_d [2];
    logic [1:0] settle_flag;
    logic settle_any_q;

    // state outputs
    logic deep;
    logic deep_entry;
    sslss_pwr_e sup_st;
    sslss_pwr_e mon_st;
    sslss_pwr_e sup_q;
    sslss_pwr_e mon_q;
    logic hazard_c;
    logic hazard_q;
    logic blocked_q;
    logic blocked_d;

    // a write lands on the edge that the master samples ack high
    always_comb begin
        req = wb_cyc_i && wb_stb_i;
        lane0 = wb_sel_i[0];
        wr_fire = req && ack_q && wb_we_i && lane0;
        ack_d = req && !ack_q;
        dat_d = dat_q;
        if (ack_d && !wb_we_i) begin
            dat_d = 32'h0000_0000;
            if (hit(wb_adr_i, `SSLSS_ADR_HCTL)) begin
                dat_d[`SSLSS_HCTL_W-1:0] = hctl_q;
            end
            if (hit(wb_adr_i, `SSLSS_ADR_LCTL)) begin
                dat_d[`SSLSS_LCTL_W-1:0] = lctl_q;
            end
            if (hit(wb_adr_i, `SSLSS_ADR_PMODE)) begin
                dat_d[`SSLSS_PMODE_W-1:0] = pmode_q;
            end
            if (hit(wb_adr_i, `SSLSS_ADR_STAT)) begin
                // settle flags, hazard, states, deep, wake hang
                dat_d[1:0] = settle_flag;
                dat_d[2] = hazard_c;
                dat_d[4:3] = sup_q;
                dat_d[6:5] = mon_q;
                dat_d[7] = deep;
                dat_d[8] = blocked_q;
            end
            if (hit(wb_adr_i, `SSLSS_ADR_ISTS)) begin
                dat_d[`SSLSS_IRQ_W-1:0] = ists_q;
            end
            if (hit(wb_adr_i, `SSLSS_ADR_IMSK)) begin
                dat_d[`SSLSS_IRQ_W-1:0] = imsk_q;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= ack_d;
            dat_q <= dat_d;
        end
    end

    // ---------------- control registers
    always_comb begin
        hctl_d = hctl_q;
        lctl_d = lctl_q;
        pmode_d = pmode_q;
        imsk_d = imsk_q;
        ctl_wr = 2'b00;
        deep_entry = 1'b0;
        if (wr_fire && hit(wb_adr_i, `SSLSS_ADR_HCTL)) begin
            hctl_d = wb_dat_i[`SSLSS_HCTL_W-1:0];
            ctl_wr[1] = 1'b1;
        end
        if (wr_fire && hit(wb_adr_i, `SSLSS_ADR_LCTL)) begin
            lctl_d = wb_dat_i[`SSLSS_LCTL_W-1:0];
            ctl_wr[0] = 1'b1;
        end
        // values above the deepest mode are ignored
        if (wr_fire && hit(wb_adr_i, `SSLSS_ADR_PMODE) &&
            wb_dat_i[`SSLSS_PMODE_W-1:0] <= `SSLSS_PMODE_MAX) begin
            pmode_d = wb_dat_i[`SSLSS_PMODE_W-1:0];
            deep_entry = !deep &&
                (wb_dat_i[`SSLSS_PMODE_W-1:0] >= `SSLSS_PMODE_DEEP);
        end
        if (wr_fire && hit(wb_adr_i, `SSLSS_ADR_IMSK)) begin
            imsk_d = wb_dat_i[`SSLSS_IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hctl_q <= `SSLSS_HCTL_RST;
            lctl_q <= `SSLSS_LCTL_RST;
            pmode_q <= `SSLSS_PMODE_RST;
            imsk_q <= `SSLSS_IMSK_RST;
        end else begin
            hctl_q <= hctl_d;
            lctl_q <= lctl_d;
            pmode_q <= pmode_d;
            imsk_q <= imsk_d;
        end
    end

    // ---------------- settle flags; software must see both low first
    for (genvar g = 0; g < 2; g++) begin : g_settle
        always_comb begin
            if (ctl_wr[g]) begin
                settle_d[g] = `SSLSS_CNT_W'(`SSLSS_SETTLE_CYC); // RULE_05
            end else if (settle_q[g] != '0) begin
                settle_d[g] = settle_q[g] - `SSLSS_CNT_W'(1);
            end else begin
                settle_d[g] = settle_q[g];
            end
            settle_flag[g] = (settle_q[g] != '0);
        end

        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                settle_q[g] <= '0;
            end else begin
                settle_q[g] <= settle_d[g];
            end
        end
    end

    // ---------------- state selection and hazard
    assign deep = (pmode_q >= `SSLSS_PMODE_DEEP);

    sslss_state_map u_sup (
        .en_i(hctl_q[`SSLSS_H_SUP_EN]),
        .fp_i(hctl_q[`SSLSS_H_SUP_FP]),
        .keep_i(hctl_q[`SSLSS_H_SUP_SEL]),
        .auto_i(hctl_q[`SSLSS_H_AUTO]),
        .deep_i(deep),
        .state_o(sup_st)
    );

    // the monitor has no keep-select; it always follows its control mode
    sslss_state_map u_mon (
        .en_i(hctl_q[`SSLSS_H_MON_EN]),
        .fp_i(hctl_q[`SSLSS_H_MON_FP]),
        .keep_i(1'b1),
        .auto_i(hctl_q[`SSLSS_H_AUTO]),
        .deep_i(deep),
        .state_o(mon_st)
    ); // RULE_04

    sslss_hazard_det u_haz (
        .hctl_i(hctl_q),
        .lctl_i(lctl_q),
        .hazard_o(hazard_c)
    ); // RULE_14

    // ---------------- events and interrupt; set wins over clear
    always_comb begin
        ev = '0;
        ev[`SSLSS_IRQ_HAZARD] = hazard_c && !hazard_q;
        ev[`SSLSS_IRQ_SETTLED] = settle_any_q && (settle_flag == 2'b00);
        ev[`SSLSS_IRQ_UNSETTLED] = deep_entry && (settle_flag != 2'b00);
        ev[`SSLSS_IRQ_WAKE_RISK] = deep_entry && hazard_c;
        ists_d = ists_q;
        if (wr_fire && hit(wb_adr_i, `SSLSS_ADR_ISTS)) begin
            ists_d = ists_q & ~wb_dat_i[`SSLSS_IRQ_W-1:0];
        end
        ists_d = ists_d | ev;
        irq_d = |(ists_d & imsk_d);
        // only a reset clears the hang; pmode writes cannot
        blocked_d = blocked_q || (deep_entry && hazard_c); // RULE_13
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ists_q <= '0;
            irq_q <= 1'b0;
            settle_any_q <= 1'b0;
            sup_q <= PWR_OFF;
            mon_q <= PWR_OFF;
            hazard_q <= 1'b0;
            blocked_q <= 1'b0;
        end else begin
            ists_q <= ists_d;
            irq_q <= irq_d;
            settle_any_q <= (settle_flag != 2'b00);
            sup_q <= sup_st;
            mon_q <= mon_st;
            hazard_q <= hazard_c; // RULE_11
            blocked_q <= blocked_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign high_sup_state_o = sup_q;
    assign high_mon_state_o = mon_q;
    assign hazard_o = hazard_q;
    assign wake_blocked_o = blocked_q;
    assign irq_o = irq_q;

    // ---------------- assertions
    sequence s_hctl_write;
        wr_fire && hit(wb_adr_i, `SSLSS_ADR_HCTL);
    endsequence

    sequence s_settle_busy;
        settle_flag[1] [*4];
    endsequence

    a_sup_active_full: assert property (@(posedge clk_i) disable iff (rst_i)
        !deep && hctl_q[`SSLSS_H_SUP_EN] && hctl_q[`SSLSS_H_SUP_FP]
        |=> high_sup_state_o == PWR_FULL) // RULE_01
        else $error("supervisor not full in active mode");

    a_sup_deep_off: assert property (@(posedge clk_i) disable iff (rst_i)
        deep && !hctl_q[`SSLSS_H_SUP_SEL]
        |=> high_sup_state_o == PWR_OFF) // RULE_02
        else $error("supervisor not off in deep mode");

    a_sup_manual_keep: assert property (@(posedge clk_i) disable iff (rst_i)
        deep && hctl_q[`SSLSS_H_SUP_EN] && hctl_q[`SSLSS_H_SUP_SEL] &&
        !hctl_q[`SSLSS_H_AUTO] && !hctl_q[`SSLSS_H_SUP_FP]
        |=> high_sup_state_o == PWR_NORMAL) // RULE_03
        else $error("manual supervisor lost its state");

    a_sup_auto_lower: assert property (@(posedge clk_i) disable iff (rst_i)
        deep && hctl_q[`SSLSS_H_SUP_EN] && hctl_q[`SSLSS_H_SUP_SEL] &&
        hctl_q[`SSLSS_H_AUTO] && hctl_q[`SSLSS_H_SUP_FP]
        |=> high_sup_state_o == PWR_NORMAL) // RULE_03
        else $error("auto supervisor not lowered");

    a_mon_auto_off: assert property (@(posedge clk_i) disable iff (rst_i)
        deep && hctl_q[`SSLSS_H_MON_EN] && hctl_q[`SSLSS_H_AUTO] &&
        !hctl_q[`SSLSS_H_MON_FP]
        |=> high_mon_state_o == PWR_OFF) // RULE_04
        else $error("auto monitor not off in deep mode");

    a_haz_sup_set: assert property (@(posedge clk_i) disable iff (rst_i)
        !lctl_q[`SSLSS_L_SUP_EN] && hctl_q[`SSLSS_H_SUP_EN] &&
        !hctl_q[`SSLSS_H_SUP_FP] && !hctl_q[`SSLSS_H_SUP_SEL]
        |=> hazard_o) // RULE_09
        else $error("supervisor hazard missed");

    a_haz_mon_set: assert property (@(posedge clk_i) disable iff (rst_i)
        lctl_q[`SSLSS_L_MON_FP] && hctl_q[`SSLSS_H_MON_EN] &&
        !hctl_q[`SSLSS_H_MON_FP] && hctl_q[`SSLSS_H_AUTO]
        |=> hazard_o) // RULE_10
        else $error("monitor hazard missed");

    a_haz_slow_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        lctl_q == `SSLSS_LCTL_W'(`SSLSS_LCTL_RST)
        |=> !hazard_o) // RULE_08
        else $error("hazard set with slow low side");

    a_settle_window: assert property (@(posedge clk_i) disable iff (rst_i)
        s_hctl_write |=> s_settle_busy ##[1:SETTLE_MAX]
        (!settle_flag[1] || ctl_wr[1]))
        // RULE_05
        // a fresh write restarts the count, so it also ends the window
        else $error("high settle flag timing wrong");

    a_wake_hang: assert property (@(posedge clk_i) disable iff (rst_i)
        deep_entry && hazard_c |=> wake_blocked_o [*3]) // RULE_13
        else $error("wake hang not latched");
endmodule : sslss_top
`default_nettype wire

// File: hw/sslss_defs.svh
// register map, field positions, reset values and timing for the
// supply supervisor low-power state selector; definitions only
`ifndef SSLSS_DEFS_SVH
`define SSLSS_DEFS_SVH

// byte addresses on the wishbone bus
`define SSLSS_ADR_HCTL 8'h00
`define SSLSS_ADR_LCTL 8'h04
`define SSLSS_ADR_PMODE 8'h08
`define SSLSS_ADR_STAT 8'h0c
`define SSLSS_ADR_ISTS 8'h10
`define SSLSS_ADR_IMSK 8'h14

// high_side_supervision_control fields
`define SSLSS_H_SUP_EN 0
`define SSLSS_H_SUP_SEL 1
`define SSLSS_H_SUP_FP 2
`define SSLSS_H_AUTO 3
`define SSLSS_H_MON_EN 4
`define SSLSS_H_MON_FP 5
`define SSLSS_HCTL_W 6
`define SSLSS_HCTL_RST 6'h00

// low_side_supervision_control fields
`define SSLSS_L_SUP_EN 0
`define SSLSS_L_SUP_FP 1
`define SSLSS_L_MON_EN 2
`define SSLSS_L_MON_FP 3
`define SSLSS_LCTL_W 4
`define SSLSS_LCTL_RST 4'h5

// power mode field: 0 active, 1 light, 2..4 deep
`define SSLSS_PMODE_W 3
`define SSLSS_PMODE_RST 3'h0
`define SSLSS_PMODE_DEEP 3'h2
`define SSLSS_PMODE_MAX 3'h4

// interrupt status / mask bits
`define SSLSS_IRQ_W 4
`define SSLSS_IRQ_HAZARD 0
`define SSLSS_IRQ_SETTLED 1
`define SSLSS_IRQ_UNSETTLED 2
`define SSLSS_IRQ_WAKE_RISK 3
`define SSLSS_IMSK_RST 4'h0

// settle time after a control write
`define SSLSS_CLK_PERIOD_NS 8
`define SSLSS_SETTLE_NS 1000
`define SSLSS_SETTLE_CYC \
    ((`SSLSS_SETTLE_NS + `SSLSS_CLK_PERIOD_NS - 1) / `SSLSS_CLK_PERIOD_NS)
`define SSLSS_CNT_W 8

`endif

// File: hw/sslss_pkg.sv
// types shared by the supply supervisor state selector modules
// assumes nothing beyond a SystemVerilog compiler
package sslss_pkg;

    typedef enum logic [1:0] {
        PWR_OFF,
        PWR_NORMAL,
        PWR_FULL
    } sslss_pwr_e;

endpackage : sslss_pkg

// File: hw/sslss_state_map.sv
// maps one supervisor or monitor's control bits to its operating state
// assumes control bits are registered on the caller's clock
`timescale 1ns/100ps
`default_nettype none
module sslss_state_map
    import sslss_pkg::*;
(
    input wire logic en_i,       // unit enabled
    input wire logic fp_i,       // full performance select
    input wire logic keep_i,     // stay on in deep modes, one level lower under auto
    input wire logic auto_i,     // automatic control
    input wire logic deep_i,     // deep low-power mode
    output sslss_pwr_e state_o   // resulting state
);
    always_comb begin
        if (!en_i) begin
            state_o = PWR_OFF; // RULE_01
        end else if (!deep_i) begin
            state_o = fp_i ? PWR_FULL : PWR_NORMAL; // RULE_01
        end else if (!keep_i) begin
            state_o = PWR_OFF; // RULE_02
        end else if (!auto_i) begin
            state_o = fp_i ? PWR_FULL : PWR_NORMAL; // RULE_03
        end else begin
            // automatic control steps one level down
            state_o = fp_i ? PWR_NORMAL : PWR_OFF; // RULE_03
        end
    end
endmodule : sslss_state_map
`default_nettype wire

// File: hw/sslss_hazard_det.sv
// flags control settings that may block wake-up from deep modes
// assumes registered control words in the documented field layout
`timescale 1ns/100ps
`default_nettype none
`include "sslss_defs.svh"
module sslss_hazard_det (
    input wire logic [`SSLSS_HCTL_W-1:0] hctl_i, // high-side control
    input wire logic [`SSLSS_LCTL_W-1:0] lctl_i, // low-side control
    output logic hazard_o                        // affected setting
);
    function automatic logic fast_low(input logic [`SSLSS_LCTL_W-1:0] l);
        fast_low = !l[`SSLSS_L_SUP_EN] || l[`SSLSS_L_SUP_FP] ||
            !l[`SSLSS_L_MON_EN] || l[`SSLSS_L_MON_FP]; // RULE_08
    endfunction : fast_low

    logic sup_hit;
    logic mon_hit;

    always_comb begin
        sup_hit = hctl_i[`SSLSS_H_SUP_EN] && !hctl_i[`SSLSS_H_SUP_FP] &&
            (!hctl_i[`SSLSS_H_SUP_SEL] || hctl_i[`SSLSS_H_AUTO]); // RULE_09
        mon_hit = hctl_i[`SSLSS_H_MON_EN] && !hctl_i[`SSLSS_H_MON_FP] &&
            hctl_i[`SSLSS_H_AUTO]; // RULE_10
        // pure combinational so it follows the registers at once
        hazard_o = fast_low(lctl_i) && (sup_hit || mon_hit); // RULE_11
    end
endmodule : sslss_hazard_det
`default_nettype wire

// File: verif/sslss_top_tb.sv
// self-checking bench for the supervisor state selector top
// assumes the design files under hw and the shared register defines
`timescale 1ns/100ps
`default_nettype none
`include "sslss_defs.svh"
module sslss_top_tb
    import sslss_pkg::*;
;
    logic clk_i;
    logic rst_i;
    logic wb_cyc_i;
    logic wb_stb_i;
    logic wb_we_i;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    sslss_pwr_e high_sup_state_o;
    sslss_pwr_e high_mon_state_o;
    logic hazard_o;
    logic wake_blocked_o;
    logic irq_o;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic [5:0] h;
    logic [3:0] l;
    logic fast;
    logic deep;
    logic exp_haz;

    sslss_top dut_u (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .high_sup_state_o(high_sup_state_o),
        .high_mon_state_o(high_mon_state_o),
        .hazard_o(hazard_o),
        .wake_blocked_o(wake_blocked_o),
        .irq_o(irq_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task wrap_up;
        if (bad_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    // run is about 26k cycles, mostly the pre-sleep pause; wide margin
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            bad_count++;
            $display("Error timeout expected done seen hang");
            wrap_up();
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // one classic cycle; holds everything until ack is sampled high
    task automatic wb_xfer(input logic we, input logic [7:0] a,
                           input logic [31:0] d, input logic [3:0] s);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb_xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb_xfer(1'b1, a, d, 4'hf);
    endtask : wr

    task automatic rdr(input logic [7:0] a);
        wb_xfer(1'b0, a, 32'h0, 4'hf);
    endtask : rdr

    task automatic do_reset;
        rst_i <= 1'b1;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask : do_reset

    task automatic chk_reset;
        rdr(`SSLSS_ADR_HCTL);
        chk("hctl", 32'h0, rd);
        rdr(`SSLSS_ADR_LCTL);
        chk("lctl", 32'h5, rd);
        rdr(`SSLSS_ADR_PMODE);
        chk("pmode", 32'h0, rd);
        rdr(`SSLSS_ADR_ISTS);
        chk("ists", 32'h0, rd);
        rdr(`SSLSS_ADR_IMSK);
        chk("imsk", 32'h0, rd);
        chk("wake_blocked_o", 32'h0, {31'h0, wake_blocked_o});
        chk("hazard_o", 32'h0, {31'h0, hazard_o});
        chk("irq_o", 32'h0, {31'h0, irq_o});
        chk("sup", {30'h0, PWR_OFF}, {30'h0, high_sup_state_o});
    endtask : chk_reset

    function automatic sslss_pwr_e lvl(input logic fp, input logic low);
        if (low) begin
            return fp ? PWR_NORMAL : PWR_OFF;
        end
        return fp ? PWR_FULL : PWR_NORMAL;
    endfunction : lvl

    initial begin
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        do_reset();
        chk_reset();
        // fast low side plus a supervisor that drops to off
        wr(`SSLSS_ADR_IMSK, 32'h1);
        wr(`SSLSS_ADR_LCTL, 32'h0);
        wr(`SSLSS_ADR_HCTL, 32'h1);
        rdr(`SSLSS_ADR_STAT);
        chk("settle flags", 32'h7, rd & 32'h7);
        chk("hazard_o", 32'h1, {31'h0, hazard_o});
        chk("irq_o", 32'h1, {31'h0, irq_o});
        // deep entry while unsettled and affected
        wr(`SSLSS_ADR_PMODE, 32'h2);
        repeat (3) @(posedge clk_i);
        chk("wake_blocked_o", 32'h1, {31'h0, wake_blocked_o});
        chk("sup", {30'h0, PWR_OFF}, {30'h0, high_sup_state_o});
        rdr(`SSLSS_ADR_ISTS);
        chk("ists deep", 32'hd, rd & 32'hd);
        wr(`SSLSS_ADR_IMSK, 32'h0);
        repeat (2) @(posedge clk_i);
        chk("irq_o masked", 32'h0, {31'h0, irq_o});
        wr(`SSLSS_ADR_ISTS, 32'hd);
        wr(`SSLSS_ADR_IMSK, 32'h1);
        repeat (2) @(posedge clk_i);
        chk("irq_o cleared", 32'h0, {31'h0, irq_o});
        // software waits out the settle time before deep entry
        wr(`SSLSS_ADR_PMODE, 32'h0);
        repeat (140) @(posedge clk_i);
        rdr(`SSLSS_ADR_STAT);
        chk("settle flags", 32'h0, rd & 32'h3);
        rdr(`SSLSS_ADR_ISTS);
        chk("ists settled", 32'h2, rd & 32'h2);
        wr(`SSLSS_ADR_ISTS, 32'hf);
        // 150 us pause before the deeper sleep, 8 ns per cycle
        repeat (18750) @(posedge clk_i);
        wr(`SSLSS_ADR_PMODE, 32'h3);
        rdr(`SSLSS_ADR_ISTS);
        chk("ists unsettled", 32'h0, rd & 32'h4);
        // refused writes
        wr(`SSLSS_ADR_PMODE, 32'h5);
        rdr(`SSLSS_ADR_PMODE);
        chk("pmode", 32'h3, rd);
        wb_xfer(1'b1, `SSLSS_ADR_HCTL, 32'h3f, 4'he);
        rdr(`SSLSS_ADR_HCTL);
        chk("hctl", 32'h1, rd);
        wr(8'h18, 32'hffffffff);
        rdr(8'h18);
        chk("unmapped", 32'h0, rd);
        do_reset();
        chk_reset();
        // hazard detector over every control combination
        for (int i = 0; i < 16; i++) begin
            l = i[3:0];
            wr(`SSLSS_ADR_LCTL, {28'h0, l});
            fast = !l[`SSLSS_L_SUP_EN] | l[`SSLSS_L_SUP_FP]
                | !l[`SSLSS_L_MON_EN] | l[`SSLSS_L_MON_FP];
            for (int j = 0; j < 64; j++) begin
                h = j[5:0];
                wr(`SSLSS_ADR_HCTL, {26'h0, h});
                repeat (2) @(posedge clk_i);
                exp_haz = fast & ((h[`SSLSS_H_SUP_EN] & !h[`SSLSS_H_SUP_FP]
                    & (!h[`SSLSS_H_SUP_SEL] | h[`SSLSS_H_AUTO]))
                    | (h[`SSLSS_H_MON_EN] & !h[`SSLSS_H_MON_FP]
                    & h[`SSLSS_H_AUTO]));
                chk("hazard_o", {31'h0, exp_haz}, {31'h0, hazard_o});
            end
        end
        // state selection over every control word and power mode
        for (int j = 0; j < 64; j++) begin
            h = j[5:0];
            wr(`SSLSS_ADR_HCTL, {26'h0, h});
            for (int k = 0; k < 5; k++) begin
                wr(`SSLSS_ADR_PMODE, k);
                repeat (2) @(posedge clk_i);
                deep = (k >= 2);
                chk("sup", {30'h0, !h[`SSLSS_H_SUP_EN] ? PWR_OFF
                    : !deep ? lvl(h[`SSLSS_H_SUP_FP], 1'b0)
                    : !h[`SSLSS_H_SUP_SEL] ? PWR_OFF
                    : lvl(h[`SSLSS_H_SUP_FP], h[`SSLSS_H_AUTO])},
                    {30'h0, high_sup_state_o});
                chk("mon", {30'h0, !h[`SSLSS_H_MON_EN] ? PWR_OFF
                    : lvl(h[`SSLSS_H_MON_FP], deep & h[`SSLSS_H_AUTO])},
                    {30'h0, high_mon_state_o});
            end
        end
        wrap_up();
    end
endmodule : sslss_top_tb
`default_nettype wire
